// *** rtl/sfs_sequencer.sv ***
// Scan frame segment sequencer: segments, blanking slots, pre-charge.
// Assumes grayscale clock, latch strobe and shift clock are synchronous
// inputs; the current scan line's grayscale words come from outside.
`timescale 1ns/1ps
`default_nettype none
module sfs_sequencer
  import sfs_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CH
)
(
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_grayscale_clock,
  input  wire logic                        i_latch_strobe,
  input  wire logic                        i_data_shift_clock,
  input  wire sfs_pkg::sfs_cmd_t           i_cmd,
  input  wire logic [CHANNELS*GRAY_W-1:0]  i_gray,
  output logic [CHANNELS-1:0]              o_channel_on,
  output logic [CHANNELS-1:0]              o_precharge,
  output logic                             o_blank,
  output logic [SCAN_W-1:0]                o_scan_line,
  output logic [SEG_W-1:0]                 o_segment,
  output logic                             o_running
);
  import sfs_pkg::*;

  // Refused at elaboration so a bad width never reaches the generate loop
  if (CHANNELS < 1 || CHANNELS > 64)
  begin : g_bad_channels
    $error("CHANNELS out of range");
  end

  typedef struct packed {
    sfs_state_t        state;
    sfs_cmd_t          cmd;
    logic              gck_q;
    logic              dck_q;
    logic [2:0]        start_cnt;
    logic [TICK_W-1:0] tick;
    logic [SCAN_W-1:0] scan;
    logic [SEG_W-1:0]  seg;
  } sfs_seq_t;

  sfs_seq_t st;
  sfs_seq_t next_st;

  logic              tick_ev;
  logic              frame_start;
  logic              run;
  logic              blank;
  logic [TICK_W-1:0] seg_ticks;
  logic [TICK_W-1:0] tick_last;
  logic [SEG_W-1:0]  seg_last;
  logic [SCAN_W-1:0] scan_last;

  assign run       = st.state == SFS_RUN;
  assign tick_ev   = i_grayscale_clock != st.gck_q;
  assign seg_ticks = st.cmd.refresh_high ? SEG_TICKS_HI : SEG_TICKS_LO;
  assign seg_last  = st.cmd.refresh_high ? SEG_LAST_HI : SEG_LAST_LO;
  assign tick_last = seg_ticks + BLANK_TICKS - TICK_W'(1);
  assign blank     = st.tick >= seg_ticks;
  assign frame_start = i_latch_strobe && i_data_shift_clock && !st.dck_q
                       && st.start_cnt == START_PULSES - 3'h1;

  always_comb
  begin
    case (st.cmd.scan_mode)
      SCAN_TWO:   scan_last = SCAN_LAST_TWO;
      SCAN_FOUR:  scan_last = SCAN_LAST_FOUR;
      SCAN_EIGHT: scan_last = SCAN_LAST_EIGHT;
      default:    scan_last = '0;
    endcase
  end

  always_comb
  begin
    next_st       = st;
    next_st.gck_q = i_grayscale_clock;
    next_st.dck_q = i_data_shift_clock;
    if (!i_latch_strobe)
      next_st.start_cnt = '0;
    else if (i_data_shift_clock && !st.dck_q && st.start_cnt != START_PULSES)
      next_st.start_cnt = st.start_cnt + 3'h1;
    case (st.state)
      SFS_IDLE:
      begin
        if (frame_start && i_cmd.scan_mode != SCAN_RESERVED)
          next_st.state = SFS_RUN;
      end
      SFS_RUN:
      begin
        if (tick_ev)
        begin
          // Segment order interleaves scan lines: seg k of every line, then k+1
          if (st.tick == tick_last)
          begin
            next_st.tick = '0;
            if (st.scan == scan_last)
            begin
              next_st.scan = '0;
              next_st.seg  = (st.seg == seg_last) ? '0 : st.seg + SEG_W'(1);
            end
            else
              next_st.scan = st.scan + SCAN_W'(1);
          end
          else
            next_st.tick = st.tick + TICK_W'(1);
        end
        if (frame_start && i_cmd.scan_mode == SCAN_RESERVED)
          next_st.state = SFS_IDLE;
      end
      default:
        next_st.state = SFS_IDLE;
    endcase
    // Command taken only at frame start so counters never straddle two modes
    if (frame_start)
    begin
      next_st.cmd  = i_cmd;
      next_st.tick = '0;
      next_st.scan = '0;
      next_st.seg  = '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st           <= '0;
      st.state     <= SFS_IDLE;
      st.cmd       <= CMD_RESET;
    end
    else
      st <= next_st;
  end

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_ch
      sfs_chan_out_t ch_out;
      sfs_chan_pdm u_ch (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_run          (run),
        .i_blank        (blank),
        .i_precharge_en (st.cmd.precharge_en),
        .i_refresh_high (st.cmd.refresh_high),
        .i_gray         (i_gray[gi*GRAY_W +: GRAY_W]),
        .i_seg          (st.seg),
        .i_tick         (st.tick),
        .o_out          (ch_out)
      );
      assign o_channel_on[gi] = ch_out.on;
      assign o_precharge[gi]  = ch_out.precharge;
    end
  endgenerate

  assign o_blank     = run && blank;
  assign o_scan_line = st.scan;
  assign o_segment   = st.seg;
  assign o_running   = run;

  sequence s_seg_end;
    run && tick_ev && !frame_start && st.tick == seg_ticks - TICK_W'(1);
  endsequence

  sequence s_blank_end;
    run && tick_ev && !frame_start && st.tick == tick_last;
  endsequence

  AST_BLANK_START: assert property (@(posedge i_clk) disable iff (i_rst)
    s_seg_end |=> o_blank && st.tick == seg_ticks)
    else $error("blanking slot did not start after segment");

  AST_BLANK_STOP: assert property (@(posedge i_clk) disable iff (i_rst)
    s_blank_end |=> !o_blank && st.tick == '0)
    else $error("blanking slot not two ticks long");

  AST_HOLD_NO_EDGE: assert property (@(posedge i_clk) disable iff (i_rst)
    run && !tick_ev && !frame_start |=> $stable(st.tick))
    else $error("tick moved without a clock edge");

  AST_SEG_COUNT: assert property (@(posedge i_clk) disable iff (i_rst)
    s_blank_end ##0 (st.scan == scan_last && st.seg != SEG_LAST_LO)
    |=> st.seg == $past(st.seg) + SEG_W'(1))
    else $error("segment did not advance after last scan line");

  AST_SEG_LENGTH: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_blank) |-> st.tick == (st.cmd.refresh_high ? SEG_TICKS_HI : SEG_TICKS_LO))
    else $error("segment length does not match refresh select");

  AST_SCAN_WRAP: assert property (@(posedge i_clk) disable iff (i_rst)
    s_blank_end ##0 (st.scan == scan_last) |=> st.scan == '0 && scan_last != '0)
    else $error("scan line did not wrap at N");

  AST_DARK_BLANK: assert property (@(posedge i_clk) disable iff (i_rst)
    o_blank |=> o_channel_on == '0)
    else $error("channel lit during blanking");

  AST_PRECHARGE_ON: assert property (@(posedge i_clk) disable iff (i_rst)
    o_blank && st.cmd.precharge_en |=> o_precharge == '1)
    else $error("pre-charge missing in blanking slot");

  AST_PRECHARGE_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_blank |=> o_precharge == '0)
    else $error("pre-charge outside blanking slot");

  AST_FRAME_RESTART: assert property (@(posedge i_clk) disable iff (i_rst)
    frame_start |=> st.tick == '0 && st.scan == '0 && st.seg == '0)
    else $error("frame start did not clear counters");

endmodule
`default_nettype wire

// *** rtl/sfs_pkg.sv ***
// Constants and carrier types of the scan frame segment sequencer.
// Assumes a single clock domain; all link inputs are synchronous to it.
package sfs_pkg;

  localparam int unsigned NUM_CH      = 16;
  localparam int unsigned GRAY_W      = 16;
  localparam int unsigned TICK_W      = 11;
  localparam int unsigned SEG_W       = 8;
  localparam int unsigned SCAN_W      = 3;

  // Ticks are grayscale clock edges: two per double-edge clock
  localparam logic [TICK_W-1:0] SEG_TICKS_LO = 11'h400;
  localparam logic [TICK_W-1:0] SEG_TICKS_HI = 11'h100;
  localparam logic [TICK_W-1:0] BLANK_TICKS  = 11'h002;
  localparam logic [SEG_W-1:0]  SEG_LAST_LO  = 8'h3F;
  localparam logic [SEG_W-1:0]  SEG_LAST_HI  = 8'hFF;
  localparam int unsigned       REM_SHIFT_LO = 6;
  localparam int unsigned       REM_SHIFT_HI = 8;

  localparam logic [1:0] SCAN_RESERVED = 2'h0;
  localparam logic [1:0] SCAN_TWO      = 2'h1;
  localparam logic [1:0] SCAN_FOUR     = 2'h2;
  localparam logic [1:0] SCAN_EIGHT    = 2'h3;
  localparam logic [SCAN_W-1:0] SCAN_LAST_TWO   = 3'h1;
  localparam logic [SCAN_W-1:0] SCAN_LAST_FOUR  = 3'h3;
  localparam logic [SCAN_W-1:0] SCAN_LAST_EIGHT = 3'h7;

  localparam logic [2:0] START_PULSES = 3'h4;

  localparam logic REFRESH_LOW  = 1'b0;
  localparam logic REFRESH_HIGH = 1'b1;

  typedef struct packed {
    logic [1:0] scan_mode;
    logic       precharge_en;
    logic       refresh_high;
  } sfs_cmd_t;

  localparam sfs_cmd_t CMD_RESET = '{scan_mode: SCAN_RESERVED, precharge_en: 1'b0,
                                     refresh_high: REFRESH_LOW};

  typedef enum logic [1:0] {
    SFS_IDLE = 2'b01,
    SFS_RUN  = 2'b10
  } sfs_state_t;

  typedef struct packed {
    logic on;
    logic precharge;
  } sfs_chan_out_t;

endpackage

// *** rtl/sfs_chan_pdm.sv ***
// One output channel of the interleaved density modulator.
// Assumes tick and segment indices come from the sequencer registers.
`timescale 1ns/1ps
`default_nettype none
module sfs_chan_pdm
  import sfs_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_run,
  input  wire logic                   i_blank,
  input  wire logic                   i_precharge_en,
  input  wire logic                   i_refresh_high,
  input  wire logic [GRAY_W-1:0]      i_gray,
  input  wire logic [SEG_W-1:0]       i_seg,
  input  wire logic [TICK_W-1:0]      i_tick,
  output var  sfs_pkg::sfs_chan_out_t o_out
);
  import sfs_pkg::*;

  sfs_chan_out_t st;
  sfs_chan_out_t next_st;
  logic [TICK_W-1:0] quota;
  logic              extra;

  // Whole share per segment plus one for the first rem segments
  always_comb
  begin
    if (i_refresh_high)
    begin
      quota = TICK_W'(i_gray >> REM_SHIFT_HI);
      extra = i_seg < SEG_W'(i_gray[REM_SHIFT_HI-1:0]);
    end
    else
    begin
      quota = TICK_W'(i_gray >> REM_SHIFT_LO);
      extra = i_seg[REM_SHIFT_LO-1:0] < i_gray[REM_SHIFT_LO-1:0];
    end
    next_st.on        = i_run && !i_blank && (i_tick < quota + TICK_W'(extra));
    next_st.precharge = i_run && i_blank && i_precharge_en;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_out = st;

endmodule
`default_nettype wire

// *** bench/sfs_ctl_model.sv ***
// Display controller model: grayscale clock, latch strobe, shift clock.
// Assumes the bench calls its tasks; outputs change on i_clk rising edges.
`timescale 1ns/1ps
`default_nettype none
module sfs_ctl_model
(
  input  wire logic i_clk,
  output var  logic o_grayscale_clock,
  output var  logic o_latch_strobe,
  output var  logic o_data_shift_clock
);
  initial
  begin
    o_grayscale_clock  = 1'b0;
    o_latch_strobe     = 1'b0;
    o_data_shift_clock = 1'b0;
  end

  // Each level held two clocks, so a blanking slot spans four
  task automatic toggle(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clk);
      o_grayscale_clock <= ~o_grayscale_clock;
      @(posedge i_clk);
    end
  endtask

  task automatic frame_start();
    @(posedge i_clk);
    o_latch_strobe <= 1'b1;
    repeat (4)
    begin
      @(posedge i_clk);
      o_data_shift_clock <= 1'b1;
      @(posedge i_clk);
      o_data_shift_clock <= 1'b0;
    end
    @(posedge i_clk);
    o_latch_strobe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/test_scan_frame_segment_sequencer.sv ***
// Self-checking bench for the scan frame segment sequencer.
// Assumes the controller model drives the link; bench drives command and grayscale.
`timescale 1ns/1ps
`default_nettype none
module test_scan_frame_segment_sequencer;
  import sfs_pkg::*;
  logic                       i_clk = 1'b0;
  logic                       i_rst = 1'b1;
  sfs_cmd_t                   cmd   = CMD_RESET;
  logic [NUM_CH*GRAY_W-1:0]   gray  = {{(NUM_CH-1){16'h0000}}, 16'hFFFF};
  wire logic                  grayscale_clock;
  wire logic                  lat;
  wire logic                  data_shift_clock;
  logic [NUM_CH-1:0]          chan_on;
  logic [NUM_CH-1:0]          prech;
  logic                       blank;
  logic [SCAN_W-1:0]          scan;
  logic [SEG_W-1:0]           seg;
  logic                       running;
  int                         err_count = 0;
  int                         cmp_count = 0;

  always #20 i_clk = ~i_clk;

  sfs_ctl_model ctl (.i_clk(i_clk), .o_grayscale_clock(grayscale_clock), .o_latch_strobe(lat),
                     .o_data_shift_clock(data_shift_clock));

  sfs_sequencer uut (.i_clk(i_clk), .i_rst(i_rst), .i_grayscale_clock(grayscale_clock),
                     .i_latch_strobe(lat), .i_data_shift_clock(data_shift_clock), .i_cmd(cmd),
                     .i_gray(gray), .o_channel_on(chan_on), .o_precharge(prech),
                     .o_blank(blank), .o_scan_line(scan), .o_segment(seg),
                     .o_running(running));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Lets the tick counter and the registered outputs catch up
  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  task automatic start(input logic [1:0] mode, input logic pc, input logic hi);
    @(posedge i_clk);
    cmd <= '{scan_mode: mode, precharge_en: pc, refresh_high: hi};
    ctl.frame_start();
    settle();
  endtask

  task automatic t_reserved();
    start(SCAN_RESERVED, 1'b0, REFRESH_LOW);
    check(running, 1'b0, "reserved mode runs");
  endtask

  task automatic t_low_blank();
    start(SCAN_EIGHT, 1'b1, REFRESH_LOW);
    check(running, 1'b1, "not running");
    check({seg, scan}, 11'h000, "frame start position");
    ctl.toggle(8);
    settle();
    check(chan_on[1:0], 2'b01, "full and zero channels");
    check(blank, 1'b0, "early blank");
    ctl.toggle(1016);
    settle();
    check(blank, 1'b1, "blank after 512 clocks");
    check(chan_on, '0, "outputs lit in blank");
    check(prech, {NUM_CH{1'b1}}, "no pre-charge");
    ctl.toggle(1);
    settle();
    check(blank, 1'b1, "blank shorter than one clock");
    ctl.toggle(1);
    settle();
    check({blank, scan}, 4'h1, "next scan line");
    check(prech, '0, "pre-charge outside blank");
  endtask

  task automatic t_high();
    @(posedge i_clk);
    gray[GRAY_W +: GRAY_W] <= 16'h0102;
    start(SCAN_TWO, 1'b0, REFRESH_HIGH);
    ctl.toggle(1);
    settle();
    check(chan_on[1], 1'b1, "inside two-tick share");
    ctl.toggle(1);
    settle();
    check(chan_on[1], 1'b0, "share of segment exceeded");
    ctl.toggle(254);
    settle();
    check(blank, 1'b1, "blank after 128 clocks");
    check(prech, '0, "pre-charge while disabled");
    check(chan_on, '0, "outputs lit in blank");
    ctl.toggle(260);
    settle();
    check({seg, scan}, 11'h008, "interleave with two lines");
  endtask

  task automatic t_restart();
    start(SCAN_FOUR, 1'b0, REFRESH_LOW);
    check({running, seg, scan}, 12'h800, "mid-frame restart");
    ctl.toggle(1026 * 4);
    settle();
    check({seg, scan}, 11'h008, "four lines per segment");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    check({running, blank, chan_on, prech}, '0, "reset state");
    t_reserved();
    t_low_blank();
    t_high();
    t_restart();
    give_verdict();
  end
endmodule
`default_nettype wire
